// file: core/tmoc_ctrl.sv
// Contract
// - nonzero action field routes waveform to pin
// - non-PWM: off, toggle, clear, set on match
// - fast PWM: 10 non-inverting, 11 inverting
// - PWM action 01: off, or A toggles
// - fast PWM: match at TOP ignored
// - dual-slope: clear up, set down, or reverse
// - mode field from control A and B
// - normal and CLEAR_ON_MATCH_MODE tops, immediate update
// - phase-correct tops, update TOP, flag BOTTOM
// - fast PWM tops, update and flag TOP
// - PFC tops, update and flag BOTTOM
// - filter needs four equal capture samples
// - edge bit: zero falling, one rising
// - capture edge copies count, sets flag
// - capture off when capture is TOP
// - clock select: stop, prescale, external edges
// - external pin counts even as output
// - force bit applies match, non-PWM only
// - force: no flag, no clear, reads zero
//
// Added by the designer: strobed register access.
module tmoc_ctrl
   import tmoc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire tmoc_timer_in_t timer_in,
   input wire logic ext_count_pin,
   input wire logic capture_pin,
   input wire logic dir_out_a,
   input wire logic dir_out_b,
   output logic count_tick,
   output logic [15:0] top_value,
   output logic [1:0] upd_point,
   output logic [1:0] ovf_point,
   output logic match_a,
   output logic match_b,
   output logic capture_flag,
   output logic [15:0] capture_word,
   output logic compare_out_a,
   output logic compare_out_b,
   output logic pin_sel_a,
   output logic pin_sel_b,
   output logic pin_oe_a,
   output logic pin_oe_b
);

   // ==========================================================
   // state
   // ==========================================================
   typedef struct packed {
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [7:0] rdata;
      logic [9:0] presc;
      logic tick;
      logic ext_prev;
      logic [3:0] samples;
      logic cap_in;
      logic cap_prev;
      logic cap_flag;
      logic [15:0] cap_word;
      logic [15:0] top;
      logic [1:0] upd;
      logic [1:0] ovf;
      logic hit_a;
      logic hit_b;
      logic [1:0] wave;
      logic [1:0] sel;
      logic [1:0] oe;
   } tmoc_state_t;

   tmoc_state_t state_reg;
   tmoc_state_t state_next;

   // ==========================================================
   // mode decode
   // ==========================================================
   function automatic tmoc_mode_t decode(input logic [3:0] m);
      tmoc_mode_t d;
      d = '{cls: WC_NONPWM, tsrc: TOP_FIXED, fixed_top: TOP_MAX, upd_at: PT_IMM, ovf_at: PT_MAX};
      case (m)
         WM_NORMAL: d.cls = WC_NONPWM;
         WM_CTC_CMP: d.tsrc = TOP_CMP_A;
         WM_CTC_CAP: d.tsrc = TOP_CAPTURE;
         WM_PC8, WM_PC9, WM_PC10, WM_PC_CAP, WM_PC_CMP:
         begin
            d.cls = WC_PHASE;
            d.upd_at = PT_TOP;
            d.ovf_at = PT_BOT;
            d.fixed_top = (m == WM_PC8) ? TOP_8 : (m == WM_PC9) ? TOP_9 : TOP_10;
            d.tsrc = (m == WM_PC_CAP) ? TOP_CAPTURE : (m == WM_PC_CMP) ? TOP_CMP_A : TOP_FIXED;
         end
         WM_FP8, WM_FP9, WM_FP10, WM_FP_CAP, WM_FP_CMP:
         begin
            d.cls = WC_FAST;
            d.upd_at = PT_TOP;
            d.ovf_at = PT_TOP;
            d.fixed_top = (m == WM_FP8) ? TOP_8 : (m == WM_FP9) ? TOP_9 : TOP_10;
            d.tsrc = (m == WM_FP_CAP) ? TOP_CAPTURE : (m == WM_FP_CMP) ? TOP_CMP_A : TOP_FIXED;
         end
         WM_PFC_CAP, WM_PFC_CMP:
         begin
            d.cls = WC_PHASE;
            d.upd_at = PT_BOT;
            d.ovf_at = PT_BOT;
            d.tsrc = (m == WM_PFC_CAP) ? TOP_CAPTURE : TOP_CMP_A;
         end
         default: d.cls = WC_RSVD;
      endcase
      return d;
   endfunction

   // ==========================================================
   // waveform action for one channel
   // ==========================================================
   function automatic logic wave_step(input logic cur, input logic [1:0] act,
                                      input tmoc_class_t cls, input logic hit,
                                      input logic bot, input logic down, input logic tog_ok);
      logic nxt;
      nxt = cur;
      case (cls)
         WC_NONPWM:
         begin
            if (hit && act == ACT_TOGGLE)
               nxt = ~cur;
            else if (hit && act[1])
               nxt = act[0];
         end
         WC_FAST:
         begin
            // match first, then BOTTOM; both at once only when compare is BOTTOM
            if (act[1] && hit)
               nxt = act[0];
            if (act[1] && bot)
               nxt = ~act[0];
            if (act == ACT_TOGGLE && tog_ok && hit)
               nxt = ~cur;
         end
         WC_PHASE:
         begin
            if (act[1] && hit)
               nxt = down ? ~act[0] : act[0];
            if (act == ACT_TOGGLE && tog_ok && hit)
               nxt = ~cur;
         end
         default: nxt = cur;
      endcase
      return nxt;
   endfunction

   // ==========================================================
   // next state
   // ==========================================================
   tmoc_mode_t md;
   logic [3:0] mode_sel;
   logic [1:0] act [2];
   logic [15:0] cmp [2];
   logic [1:0] force_hit;
   logic [1:0] raw_hit;
   logic at_bottom;
   logic [15:0] top_now;
   logic ext_edge;
   logic cap_edge;
   logic cap_enabled;
   logic wr_force;

   always_comb
   begin
      state_next = state_reg;
      mode_sel = {state_reg.ctrl_b[MODE_HI_HI:MODE_HI_LO],
                  state_reg.ctrl_a[MODE_LO_HI:MODE_LO_LO]};
      md = decode(mode_sel);
      act[0] = state_reg.ctrl_a[ACT_A_HI:ACT_A_LO];
      act[1] = state_reg.ctrl_a[ACT_B_HI:ACT_B_LO];
      cmp[0] = timer_in.compare_value_a;
      cmp[1] = timer_in.compare_value_b;
      case (md.tsrc)
         TOP_CMP_A: top_now = timer_in.compare_value_a;
         TOP_CAPTURE: top_now = timer_in.capture_value;
         default: top_now = md.fixed_top;
      endcase
      state_next.top = top_now;
      state_next.upd = md.upd_at;
      state_next.ovf = md.ovf_at;

      // register port; force bits are strobes and never stored
      wr_force = reg_write && reg_addr == FORCE_CTRL_ADDR;
      if (reg_write && reg_addr == ACT_MODE_CTRL_ADDR)
         state_next.ctrl_a = reg_wdata & CTRL_A_MASK;
      if (reg_write && reg_addr == CAP_CLK_CTRL_ADDR)
         state_next.ctrl_b = reg_wdata & CTRL_B_MASK;
      state_next.rdata = CTRL_RESET;
      if (reg_read && reg_addr == ACT_MODE_CTRL_ADDR)
         state_next.rdata = state_reg.ctrl_a;
      if (reg_read && reg_addr == CAP_CLK_CTRL_ADDR)
         state_next.rdata = state_reg.ctrl_b;

      // prescaler runs free; external pin sampled regardless of its direction
      state_next.presc = state_reg.presc + PRESC_ONE;
      state_next.ext_prev = ext_count_pin;
      ext_edge = 1'b0;
      case (state_reg.ctrl_b[TSRC_HI:TSRC_LO])
         TS_STOP: state_next.tick = 1'b0;
         TS_DIV1: state_next.tick = 1'b1;
         TS_DIV8: state_next.tick = (state_reg.presc & DIV8_MASK) == DIV8_MASK;
         TS_DIV64: state_next.tick = (state_reg.presc & DIV64_MASK) == DIV64_MASK;
         TS_DIV256: state_next.tick = (state_reg.presc & DIV256_MASK) == DIV256_MASK;
         TS_DIV1024: state_next.tick = state_reg.presc == DIV1024_MASK;
         TS_EXT_FALL: ext_edge = state_reg.ext_prev && !ext_count_pin;
         TS_EXT_RISE: ext_edge = !state_reg.ext_prev && ext_count_pin;
         default: state_next.tick = 1'b0;
      endcase
      if (state_reg.ctrl_b[TSRC_HI:TSRC_LO] >= TS_EXT_FALL)
         state_next.tick = ext_edge;

      // capture input: optional four-sample filter, then edge pick
      state_next.samples = {state_reg.samples[2:0], capture_pin};
      if (!state_reg.ctrl_b[FILTER_BIT])
         state_next.cap_in = capture_pin;
      else if (state_reg.samples == FILT_ALL_ONE)
         state_next.cap_in = 1'b1;
      else if (state_reg.samples == FILT_ALL_ZERO)
         state_next.cap_in = 1'b0;
      state_next.cap_prev = state_reg.cap_in;
      cap_enabled = md.tsrc != TOP_CAPTURE;
      cap_edge = state_reg.ctrl_b[EDGE_BIT] ? (state_reg.cap_in && !state_reg.cap_prev)
                                            : (!state_reg.cap_in && state_reg.cap_prev);
      state_next.cap_flag = cap_edge && cap_enabled;
      if (cap_edge && cap_enabled)
         state_next.cap_word = timer_in.count_value;

      // compare matches on the timer tick; force only in non-PWM modes
      at_bottom = state_reg.tick && timer_in.count_value == BOTTOM;
      force_hit[0] = wr_force && reg_wdata[FORCE_A_BIT] && md.cls == WC_NONPWM;
      force_hit[1] = wr_force && reg_wdata[FORCE_B_BIT] && md.cls == WC_NONPWM;
      for (int i = 0; i < 2; i++)
      begin
         raw_hit[i] = state_reg.tick && timer_in.count_value == cmp[i];
         if (md.cls == WC_FAST && act[i][1] && cmp[i] == top_now)
            raw_hit[i] = 1'b0;
         state_next.wave[i] = wave_step(state_reg.wave[i], act[i], md.cls,
                                        raw_hit[i] || force_hit[i], at_bottom,
                                        timer_in.count_down,
                                        i == 0 && mode_sel[3]);
         state_next.sel[i] = act[i] != ACT_OFF;
         if (md.cls != WC_NONPWM && act[i] == ACT_TOGGLE && !(i == 0 && mode_sel[3]))
            state_next.sel[i] = 1'b0;
         state_next.oe[i] = state_next.sel[i] && (i == 0 ? dir_out_a : dir_out_b);
      end
      // flags and counter clear see true matches only, never a force
      state_next.hit_a = raw_hit[0];
      state_next.hit_b = raw_hit[1];
   end

   // ==========================================================
   // registers
   // ==========================================================
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   assign reg_rdata = state_reg.rdata;
   assign count_tick = state_reg.tick;
   assign top_value = state_reg.top;
   assign upd_point = state_reg.upd;
   assign ovf_point = state_reg.ovf;
   assign match_a = state_reg.hit_a;
   assign match_b = state_reg.hit_b;
   assign capture_flag = state_reg.cap_flag;
   assign capture_word = state_reg.cap_word;
   assign compare_out_a = state_reg.wave[0];
   assign compare_out_b = state_reg.wave[1];
   assign pin_sel_a = state_reg.sel[0];
   assign pin_sel_b = state_reg.sel[1];
   assign pin_oe_a = state_reg.oe[0];
   assign pin_oe_b = state_reg.oe[1];

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   chk_force_reads_zero: assert property (
      reg_read && reg_addr == FORCE_CTRL_ADDR |=> reg_rdata == CTRL_RESET)
      else $error("force register read not zero");

   chk_pin_route_a: assert property (
      $past(state_reg.ctrl_a[ACT_A_HI:ACT_A_LO]) == ACT_OFF |-> !pin_sel_a && !pin_oe_a)
      else $error("channel a routed while action off");

   chk_oe_needs_dir: assert property (
      pin_oe_b |-> pin_sel_b && $past(dir_out_b))
      else $error("pin b driven without direction");

   chk_stop_no_tick: assert property (
      state_reg.ctrl_b[TSRC_HI:TSRC_LO] == TS_STOP && $stable(state_reg.ctrl_b) |=> !count_tick)
      else $error("tick while stopped");

   // a tick left over from the previous source must not start the count
   chk_div8_spacing: assert property (
      count_tick && state_reg.ctrl_b[TSRC_HI:TSRC_LO] == TS_DIV8 &&
      $stable(state_reg.ctrl_b) && reg_write == 1'b0 |=> !count_tick [*7])
      else $error("divide by eight spacing wrong");

   chk_capture_copy: assert property (
      state_next.cap_flag |=> capture_flag && capture_word == $past(timer_in.count_value))
      else $error("capture value not copied");

   chk_capture_off: assert property (
      capture_flag |-> $past(md.tsrc) != TOP_CAPTURE)
      else $error("capture while capture is top");

   chk_filter_four: assert property (
      $past(state_reg.ctrl_b[FILTER_BIT]) && $rose(state_reg.cap_in) |->
      $past(state_reg.samples) == FILT_ALL_ONE)
      else $error("filter changed early");

   chk_raw_capture: assert property (
      !state_reg.ctrl_b[FILTER_BIT] |=> state_reg.cap_in == $past(capture_pin))
      else $error("unfiltered capture input lags");

   chk_capture_edge: assert property (
      capture_flag |-> $past(state_reg.cap_in) == $past(state_reg.ctrl_b[EDGE_BIT]))
      else $error("capture on wrong edge");

   chk_fast_ovf_top: assert property (
      md.cls == WC_FAST |=> ovf_point == PT_TOP && upd_point == PT_TOP)
      else $error("fast pwm points wrong");

   chk_force_no_flag: assert property (
      force_hit[0] && !state_reg.tick |=> !match_a)
      else $error("force raised a match");

   chk_force_action: assert property (
      force_hit[0] && act[0][1] |=> compare_out_a == $past(act[0][0]))
      else $error("force did not apply action");

   chk_nonpwm_toggle: assert property (
      md.cls == WC_NONPWM && (raw_hit[0] || force_hit[0]) && act[0] == ACT_TOGGLE
      |=> compare_out_a != $past(compare_out_a))
      else $error("toggle on match missing");

   chk_fast_bottom: assert property (
      md.cls == WC_FAST && act[0][1] && at_bottom |=> compare_out_a == !$past(act[0][0]))
      else $error("fast pwm bottom level wrong");

   chk_top_ignored: assert property (
      md.cls == WC_FAST && act[0][1] && cmp[0] == top_now |=> !match_a)
      else $error("match at top not ignored");

   chk_dual_slope: assert property (
      md.cls == WC_PHASE && act[0][1] && raw_hit[0] |=>
      compare_out_a == ($past(act[0][0]) ^ $past(timer_in.count_down)))
      else $error("dual slope level wrong");

   chk_pwm_b_toggle_off: assert property (
      md.cls != WC_NONPWM && act[1] == ACT_TOGGLE |=> !pin_sel_b && !pin_oe_b)
      else $error("channel b routed on reserved action");

   chk_div1_tick: assert property (
      state_reg.ctrl_b[TSRC_HI:TSRC_LO] == TS_DIV1 |=> count_tick)
      else $error("no tick at full rate");

   chk_ext_rise_tick: assert property (
      state_reg.ctrl_b[TSRC_HI:TSRC_LO] == TS_EXT_RISE && $rose(ext_count_pin) |=> count_tick)
      else $error("external rising edge lost");

endmodule

// file: pkg/tmoc_pkg.sv
package tmoc_pkg;

   // ==========================================================
   // register map (byte addresses)
   // ==========================================================
   localparam logic [7:0] FORCE_CTRL_ADDR = 8'h2C;
   localparam logic [7:0] CAP_CLK_CTRL_ADDR = 8'h2D;
   localparam logic [7:0] ACT_MODE_CTRL_ADDR = 8'h2E;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_A_MASK = 8'hF3;
   localparam logic [7:0] CTRL_B_MASK = 8'hDF;

   // ==========================================================
   // field positions
   // ==========================================================
   localparam int ACT_A_HI = 7;
   localparam int ACT_A_LO = 6;
   localparam int ACT_B_HI = 5;
   localparam int ACT_B_LO = 4;
   localparam int MODE_LO_HI = 1;
   localparam int MODE_LO_LO = 0;
   localparam int FILTER_BIT = 7;
   localparam int EDGE_BIT = 6;
   localparam int MODE_HI_HI = 4;
   localparam int MODE_HI_LO = 3;
   localparam int TSRC_HI = 2;
   localparam int TSRC_LO = 0;
   localparam int FORCE_A_BIT = 7;
   localparam int FORCE_B_BIT = 6;

   // ==========================================================
   // waveform modes, tops, clock sources
   // ==========================================================
   localparam logic [3:0] WM_NORMAL = 4'h0;
   localparam logic [3:0] WM_PC8 = 4'h1;
   localparam logic [3:0] WM_PC9 = 4'h2;
   localparam logic [3:0] WM_PC10 = 4'h3;
   localparam logic [3:0] WM_CTC_CMP = 4'h4;
   localparam logic [3:0] WM_FP8 = 4'h5;
   localparam logic [3:0] WM_FP9 = 4'h6;
   localparam logic [3:0] WM_FP10 = 4'h7;
   localparam logic [3:0] WM_PFC_CAP = 4'h8;
   localparam logic [3:0] WM_PFC_CMP = 4'h9;
   localparam logic [3:0] WM_PC_CAP = 4'hA;
   localparam logic [3:0] WM_PC_CMP = 4'hB;
   localparam logic [3:0] WM_CTC_CAP = 4'hC;
   localparam logic [3:0] WM_FP_CAP = 4'hE;
   localparam logic [3:0] WM_FP_CMP = 4'hF;
   localparam logic [15:0] TOP_MAX = 16'hFFFF;
   localparam logic [15:0] TOP_8 = 16'h00FF;
   localparam logic [15:0] TOP_9 = 16'h01FF;
   localparam logic [15:0] TOP_10 = 16'h03FF;
   localparam logic [15:0] BOTTOM = 16'h0000;

   localparam logic [2:0] TS_STOP = 3'h0;
   localparam logic [2:0] TS_DIV1 = 3'h1;
   localparam logic [2:0] TS_DIV8 = 3'h2;
   localparam logic [2:0] TS_DIV64 = 3'h3;
   localparam logic [2:0] TS_DIV256 = 3'h4;
   localparam logic [2:0] TS_DIV1024 = 3'h5;
   localparam logic [2:0] TS_EXT_FALL = 3'h6;
   localparam logic [2:0] TS_EXT_RISE = 3'h7;
   localparam logic [9:0] DIV8_MASK = 10'h007;
   localparam logic [9:0] DIV64_MASK = 10'h03F;
   localparam logic [9:0] DIV256_MASK = 10'h0FF;
   localparam logic [9:0] DIV1024_MASK = 10'h3FF;
   localparam logic [9:0] PRESC_ONE = 10'h001;

   localparam logic [1:0] ACT_OFF = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [3:0] FILT_ALL_ONE = 4'hF;
   localparam logic [3:0] FILT_ALL_ZERO = 4'h0;

   typedef enum logic [1:0] {WC_NONPWM, WC_FAST, WC_PHASE, WC_RSVD} tmoc_class_t;
   typedef enum logic [1:0] {PT_IMM, PT_MAX, PT_TOP, PT_BOT} tmoc_point_t;
   typedef enum logic [1:0] {TOP_FIXED, TOP_CMP_A, TOP_CAPTURE} tmoc_tsrc_t;

   typedef struct packed {
      tmoc_class_t cls;
      tmoc_tsrc_t tsrc;
      logic [15:0] fixed_top;
      tmoc_point_t upd_at;
      tmoc_point_t ovf_at;
   } tmoc_mode_t;

   typedef struct packed {
      logic [15:0] count_value;
      logic count_down;
      logic [15:0] compare_value_a;
      logic [15:0] compare_value_b;
      logic [15:0] capture_value;
   } tmoc_timer_in_t;

endpackage

// file: sim/tmoc_ctrl_tb.sv
module tmoc_ctrl_tb
   import tmoc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // stimulus and observed signals
   // ==========================================================
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic ext_count_pin = 1'b0;
   logic capture_pin = 1'b0;
   logic dir_out_a = 1'b0;
   logic dir_out_b = 1'b1;
   tmoc_timer_in_t tin = '{16'h0010, 1'b0, 16'h0080, 16'h0040, 16'h0200};
   logic [7:0] reg_rdata;
   logic count_tick;
   logic [15:0] top_value;
   logic [1:0] upd_point;
   logic [1:0] ovf_point;
   logic match_a;
   logic match_b;
   logic capture_flag;
   logic [15:0] capture_word;
   logic compare_out_a;
   logic compare_out_b;
   logic pin_sel_a;
   logic pin_sel_b;
   logic pin_oe_a;
   logic pin_oe_b;
   int fails = 0;
   int checked = 0;
   int ticks = 0;
   int cycles = 0;
   int n0;
   int n1;
   logic [7:0] rv;
   logic [19:0] e;
   logic o;

   tmoc_ctrl dut_u (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .reg_rdata, .timer_in(tin), .ext_count_pin, .capture_pin, .dir_out_a, .dir_out_b,
      .count_tick, .top_value, .upd_point, .ovf_point, .match_a, .match_b, .capture_flag,
      .capture_word, .compare_out_a, .compare_out_b, .pin_sel_a, .pin_sel_b, .pin_oe_a,
      .pin_oe_b);

   always #5 ref_clk = ~ref_clk;

   always @(posedge ref_clk)
   begin
      if (count_tick === 1'b1)
         ticks <= ticks + 1;
   end

   // hang guard: the whole sequence needs roughly 13000 cycles
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         fails++;
         test_done();
      end
   end

   // ==========================================================
   // tasks
   // ==========================================================
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp, input string msg);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic cfg(input logic [3:0] m, input logic [3:0] act, input logic [1:0] cap,
                      input logic [2:0] cs);
      wr(ACT_MODE_CTRL_ADDR, {act, 2'b00, m[1:0]});
      wr(CAP_CLK_CTRL_ADDR, {cap, 1'b0, m[3:2], cs});
      repeat (3) @(posedge ref_clk);
      #1;
   endtask

   task automatic cnt(input logic [15:0] v, input logic d);
      @(posedge ref_clk);
      tin.count_value <= v;
      tin.count_down <= d;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask

   task automatic frc(input logic [7:0] d);
      wr(FORCE_CTRL_ADDR, d);
      @(posedge ref_clk);
      #1;
   endtask

   // n reaches 20 when no capture flag shows
   task automatic cap(input logic lvl, output int n);
      @(posedge ref_clk);
      capture_pin <= lvl;
      n = 0;
      // let the previous flag pulse clear before looking
      #1;
      while (n < 20 && capture_flag !== 1'b1)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
   endtask

   function automatic logic [19:0] mexp(input logic [3:0] m);
      case (m)
         4'h0: return {TOP_MAX, PT_IMM, PT_MAX};
         4'h1: return {TOP_8, PT_TOP, PT_BOT};
         4'h2: return {TOP_9, PT_TOP, PT_BOT};
         4'h3: return {TOP_10, PT_TOP, PT_BOT};
         4'h4: return {16'h0080, PT_IMM, PT_MAX};
         4'h5: return {TOP_8, PT_TOP, PT_TOP};
         4'h6: return {TOP_9, PT_TOP, PT_TOP};
         4'h7: return {TOP_10, PT_TOP, PT_TOP};
         4'h8: return {16'h0200, PT_BOT, PT_BOT};
         4'h9: return {16'h0080, PT_BOT, PT_BOT};
         4'hA: return {16'h0200, PT_TOP, PT_BOT};
         4'hB: return {16'h0080, PT_TOP, PT_BOT};
         4'hC: return {16'h0200, PT_IMM, PT_MAX};
         4'hE: return {16'h0200, PT_TOP, PT_TOP};
         default: return {16'h0080, PT_TOP, PT_TOP};
      endcase
   endfunction

   // ==========================================================
   // main sequence
   // ==========================================================
   initial
   begin
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rd(ACT_MODE_CTRL_ADDR, rv);
      chk(rv, CTRL_RESET, "ctrl a reset");
      rd(CAP_CLK_CTRL_ADDR, rv);
      chk(rv, CTRL_RESET, "ctrl b reset");
      chk({top_value, upd_point, ovf_point}, mexp(4'h0), "reset mode");
      wr(8'h30, 8'hFF);
      rd(8'h30, rv);
      chk(rv, 8'h00, "unmapped read");
      wr(ACT_MODE_CTRL_ADDR, 8'hFF);
      rd(ACT_MODE_CTRL_ADDR, rv);
      chk(rv, CTRL_A_MASK, "ctrl a reserved bits");
      @(posedge ref_clk);
      #1;
      chk(reg_rdata, 8'h00, "rdata stands one cycle");
      wr(CAP_CLK_CTRL_ADDR, 8'hFF);
      rd(CAP_CLK_CTRL_ADDR, rv);
      chk(rv, CTRL_B_MASK, "ctrl b reserved bits");
      wr(FORCE_CTRL_ADDR, 8'hC0);
      rd(FORCE_CTRL_ADDR, rv);
      chk(rv, 8'h00, "force reads zero");
      // mode field split over both registers; mode 13 is reserved and skipped
      for (int m = 0; m < 16; m++)
      begin
         if (m == 13)
            continue;
         cfg(m[3:0], 4'h0, 2'b00, TS_STOP);
         e = mexp(m[3:0]);
         chk({top_value, upd_point, ovf_point}, e, "mode table");
      end
      // a window that is a multiple of every divisor gives an exact tick count
      for (int cs = 0; cs < 6; cs++)
      begin
         cfg(WM_NORMAL, 4'h0, 2'b00, cs[2:0]);
         ticks = 0;
         repeat (2048) @(posedge ref_clk);
         #1;
         e = (cs == 0) ? 0 : 2048 / ((cs == 1) ? 1 : (cs == 2) ? 8 : (cs == 3) ? 64 :
                                     (cs == 4) ? 256 : 1024);
         chk(ticks[15:0], e[15:0], "prescaled tick count");
      end
      for (int cs = 6; cs < 8; cs++)
      begin
         cfg(WM_NORMAL, 4'h0, 2'b00, cs[2:0]);
         ticks = 0;
         ext_count_pin <= 1'b1;
         repeat (6) @(posedge ref_clk);
         #1;
         chk(ticks[15:0], (cs == 7) ? 16'h0001 : 16'h0000, "ext rising");
         ext_count_pin <= 1'b0;
         repeat (6) @(posedge ref_clk);
         #1;
         chk(ticks[15:0], 16'h0001, "ext falling");
      end
      // non-PWM actions applied by force strobes with counter stopped, then one real match at full rate
      cfg(WM_NORMAL, 4'hF, 2'b00, TS_STOP);
      chk({pin_sel_a, pin_oe_a, pin_sel_b, pin_oe_b}, 4'hB, "pin routing");
      dir_out_a <= 1'b1;
      frc(8'hC0);
      chk({compare_out_a, compare_out_b, pin_oe_a, match_a}, 4'hE, "force set");
      cfg(WM_NORMAL, 4'h8, 2'b00, TS_STOP);
      frc(8'h80);
      chk(compare_out_a, 1'b0, "force clear");
      chk(pin_sel_b, 1'b0, "action off");
      cfg(WM_NORMAL, 4'h4, 2'b00, TS_STOP);
      frc(8'h80);
      chk(compare_out_a, 1'b1, "force toggle");
      frc(8'h80);
      chk(compare_out_a, 1'b0, "force toggle back");
      cfg(WM_CTC_CMP, 4'hC, 2'b00, TS_DIV1);
      cnt(16'h0080, 1'b0);
      chk({compare_out_a, match_a}, 2'b11, "real match set");
      // fast PWM, 8-bit, then TOP from compare A
      cfg(WM_FP8, 4'h8, 2'b00, TS_DIV1);
      cnt(BOTTOM, 1'b0);
      chk(compare_out_a, 1'b1, "fast set at bottom");
      cnt(16'h0080, 1'b0);
      chk(compare_out_a, 1'b0, "fast clear on match");
      cfg(WM_FP8, 4'hC, 2'b00, TS_DIV1);
      chk(compare_out_a, 1'b1, "fast inverting match");
      cnt(BOTTOM, 1'b0);
      chk(compare_out_a, 1'b0, "fast inverting bottom");
      cfg(WM_FP8, 4'h8, 2'b00, TS_DIV1);
      tin.compare_value_a <= TOP_8;
      cnt(BOTTOM, 1'b0);
      cnt(TOP_8, 1'b0);
      chk({compare_out_a, match_a}, 2'b10, "match at top ignored");
      frc(8'h80);
      chk(compare_out_a, 1'b1, "force ignored in pwm");
      tin.compare_value_a <= 16'h0080;
      cfg(WM_FP8, 4'h5, 2'b00, TS_DIV1);
      chk({pin_sel_a, pin_sel_b}, 2'b00, "pwm action 01 off");
      cfg(WM_FP_CMP, 4'h5, 2'b00, TS_DIV1);
      chk({pin_sel_a, pin_sel_b}, 2'b10, "pwm action 01 a only");
      cnt(16'h0080, 1'b0);
      o = compare_out_a;
      @(posedge ref_clk);
      #1;
      chk(compare_out_a, !o, "pwm toggle a");
      // dual slope: direction picks clear or set
      for (int k = 0; k < 2; k++)
      begin
         cfg(WM_PC8, k ? 4'hC : 4'h8, 2'b00, TS_DIV1);
         cnt(16'h0080, 1'b0);
         chk(compare_out_a, k[0], "dual slope up");
         cnt(16'h0080, 1'b1);
         chk(compare_out_a, !k[0], "dual slope down");
      end
      // capture, counter stopped so the captured value is fixed
      tin.count_value <= 16'h0ABC;
      cfg(WM_NORMAL, 4'h0, 2'b01, TS_STOP);
      cap(1'b1, n0);
      chk(capture_word, 16'h0ABC, "capture rising");
      cap(1'b0, n1);
      chk(n1 == 20, 1'b1, "no capture on falling");
      cfg(WM_NORMAL, 4'h0, 2'b00, TS_STOP);
      cap(1'b1, n1);
      chk(n1 == 20, 1'b1, "no capture on rising");
      tin.count_value <= 16'h0BCD;
      cap(1'b0, n1);
      chk(capture_word, 16'h0BCD, "capture falling");
      cfg(WM_NORMAL, 4'h0, 2'b11, TS_STOP);
      cap(1'b1, n1);
      chk((n1 - n0 >= 3) && (n1 - n0 <= 4), 1'b1, "filter delay");
      cfg(WM_NORMAL, 4'h0, 2'b10, TS_STOP);
      capture_pin <= 1'b0;
      repeat (2) @(posedge ref_clk);
      cap(1'b1, n1);
      chk(n1 == 20, 1'b1, "short glitch filtered");
      cfg(WM_CTC_CAP, 4'h0, 2'b01, TS_STOP);
      cap(1'b0, n1);
      cap(1'b1, n1);
      chk(n1 == 20, 1'b1, "capture off when it is top");
      // a reset in mid-run must clear control register B
      nrst <= 1'b0;
      @(posedge ref_clk);
      nrst <= 1'b1;
      rd(CAP_CLK_CTRL_ADDR, rv);
      chk(rv, CTRL_RESET, "ctrl b after reset");
      test_done();
   end
endmodule
